/* File: logic/irq_pkg.sv */
// shared constants and types for the interrupt flag and enable block
package irq_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_EDGE_SEL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_FIRST = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CTRL_SECOND = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_VECTOR = 4'hC;
  // first control register fields
  localparam int C0_GIE = 0;
  localparam int C0_EXT_E = 1;
  localparam int C0_ADC_E = 2;
  localparam int C0_CMPP_E = 3;
  localparam int C0_EXT_F = 4;
  localparam int C0_ADC_F = 5;
  localparam int C0_CMPP_F = 6;
  // second control register fields
  localparam int C1_CMPA_E = 0;
  localparam int C1_SER_E = 1;
  localparam int C1_TICK0_E = 2;
  localparam int C1_TICK1_E = 3;
  localparam int C1_CMPA_F = 4;
  localparam int C1_SER_F = 5;
  localparam int C1_TICK0_F = 6;
  localparam int C1_TICK1_F = 7;
  localparam logic [7:0] C0_MASK = 8'h7F;
  localparam logic [7:0] EDGE_MASK = 8'h03;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] EDGE_OFF = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // vector indices, in priority order (0 highest)
  localparam logic [2:0] VEC_EXT = 3'h0;
  localparam logic [2:0] VEC_CMPP = 3'h1;
  localparam logic [2:0] VEC_CMPA = 3'h2;
  localparam logic [2:0] VEC_ADC = 3'h3;
  localparam logic [2:0] VEC_SER = 3'h4;
  localparam logic [2:0] VEC_TICK0 = 3'h5;
  localparam logic [2:0] VEC_TICK1 = 3'h6;
  typedef struct packed {
    logic ext_pin;
    logic timer_cmp_p;
    logic timer_cmp_a;
    logic conv_done;
    logic serial;
    logic tick0;
    logic tick1;
  } irq_events_t;
  typedef struct packed {
    logic [7:0] edge_sel;
    logic [7:0] ctrl_first;
    logic [7:0] ctrl_second;
    logic pin_prev;
    logic aw_done;
    logic w_done;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } irq_state_t;
endpackage

/* File: logic/mcu_interrupt_flags_enables.sv */
// interrupt flags, enables and vectored request logic with an axi4-lite slave
// What this block does
// [RL1] ext_edge_sel: 00 off, 01 rising, 10 falling, 11 both edges on ext pin.
// [RL2] only low two bits of edge select register exist; upper bits read zero.
// [RL3] bit 7 of first control register is unimplemented and reads zero.
// [RL4] bit 0 of first control register is global enable; zero blocks all.
// [RL5] timer comparator p flag at bit 6, enable at bit 3, first register.
// [RL6] converter done flag at bit 5, enable at bit 2, first register.
// [RL7] external pin flag at bit 4, enable at bit 1, first register.
// [RL8] second register: flags high nibble, enables low; tick1, tick0, serial, cmp a.
// [RL9] flags one means pending; enables one means enabled.
// [RL10] every source has its own distinct vector index.
// [RL11] sources: external pin, timer, serial port, two time bases, converter.
// [RL12] events set flags regardless of enables; vector needs own and global enable.
// [RL13] servicing a request clears the global enable automatically.
// [RL14] flags keep recording while interrupts are blocked.
// [RL15] servicing the external pin interrupt clears its flag.
// [RL16] fixed priority for simultaneous requests; all bits reset to zero.
// [RL17] software may set and clear flags by writes.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
module mcu_interrupt_flags_enables
  import irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ext_pin,
  input wire irq_events_t unit_events,
  output logic irq_req,
  output logic [2:0] irq_vector,
  input wire logic irq_ack,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  irq_state_t st_ff;
  irq_state_t nxt_st;
  logic [6:0] pend;
  logic [2:0] win_vec;
  logic any_pend;
  logic ext_edge;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] c0_set;
  logic [7:0] c1_set;
  logic [7:0] c0_clr;

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == OFS_EDGE_SEL) || (a == OFS_CTRL_FIRST) || (a == OFS_CTRL_SECOND)
      || (a == OFS_VECTOR);
  endfunction

  // pending = flag and own enable, index equals priority
  always_comb begin
    pend[VEC_EXT] = st_ff.ctrl_first[C0_EXT_F] & st_ff.ctrl_first[C0_EXT_E]; // RL12 RL7
    pend[VEC_CMPP] = st_ff.ctrl_first[C0_CMPP_F] & st_ff.ctrl_first[C0_CMPP_E]; // RL5
    pend[VEC_CMPA] = st_ff.ctrl_second[C1_CMPA_F] & st_ff.ctrl_second[C1_CMPA_E];
    pend[VEC_ADC] = st_ff.ctrl_first[C0_ADC_F] & st_ff.ctrl_first[C0_ADC_E]; // RL6
    pend[VEC_SER] = st_ff.ctrl_second[C1_SER_F] & st_ff.ctrl_second[C1_SER_E];
    pend[VEC_TICK0] = st_ff.ctrl_second[C1_TICK0_F] & st_ff.ctrl_second[C1_TICK0_E];
    pend[VEC_TICK1] = st_ff.ctrl_second[C1_TICK1_F] & st_ff.ctrl_second[C1_TICK1_E];
    win_vec = VEC_TICK1;
    for (int i = 6; i >= 0; i--) begin
      if (pend[i]) begin
        win_vec = 3'(i); // RL16
      end
    end
    any_pend = |pend;
  end

  // request only while the global enable is up
  assign irq_req = any_pend & st_ff.ctrl_first[C0_GIE]; // RL4
  assign irq_vector = win_vec; // RL10

  // edge detect on ext pin; pin is taken as synchronous
  always_comb begin
    case (st_ff.edge_sel[1:0]) // RL1
      EDGE_RISE: ext_edge = ext_pin & ~st_ff.pin_prev;
      EDGE_FALL: ext_edge = ~ext_pin & st_ff.pin_prev;
      EDGE_BOTH: ext_edge = ext_pin ^ st_ff.pin_prev;
      default: ext_edge = 1'b0;
    endcase
  end

  assign s_axi_awready = ~st_ff.aw_done & ~st_ff.bvalid;
  assign s_axi_wready = ~st_ff.w_done & ~st_ff.bvalid;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_prev = ext_pin;
    wr_fire = 1'b0;
    c0_set = 8'h00;
    c1_set = 8'h00;
    c0_clr = 8'h00;
    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_done = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_done = 1'b1;
      nxt_st.w_data = s_axi_wdata[7:0];
      nxt_st.w_strb0 = s_axi_wstrb[0];
    end
    if (nxt_st.aw_done && nxt_st.w_done && !st_ff.bvalid) begin
      wr_fire = 1'b1;
      nxt_st.aw_done = 1'b0;
      nxt_st.w_done = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = addr_known(nxt_st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (nxt_st.w_strb0) begin
        case (nxt_st.aw_addr)
          OFS_EDGE_SEL: nxt_st.edge_sel = nxt_st.w_data & EDGE_MASK; // RL2
          OFS_CTRL_FIRST: nxt_st.ctrl_first = nxt_st.w_data & C0_MASK; // RL3 RL17
          OFS_CTRL_SECOND: nxt_st.ctrl_second = nxt_st.w_data; // RL8 RL17
          default: ;
        endcase
      end
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // service: clear global enable and the serviced flag
    if (irq_ack && irq_req) begin
      c0_clr[C0_GIE] = 1'b1; // RL13
      case (win_vec)
        VEC_EXT: c0_clr[C0_EXT_F] = 1'b1; // RL15
        VEC_CMPP: c0_clr[C0_CMPP_F] = 1'b1;
        VEC_ADC: c0_clr[C0_ADC_F] = 1'b1;
        default: ;
      endcase
    end
    nxt_st.ctrl_first = nxt_st.ctrl_first & ~c0_clr;
    if (irq_ack && irq_req) begin
      case (win_vec)
        VEC_CMPA: nxt_st.ctrl_second[C1_CMPA_F] = 1'b0;
        VEC_SER: nxt_st.ctrl_second[C1_SER_F] = 1'b0;
        VEC_TICK0: nxt_st.ctrl_second[C1_TICK0_F] = 1'b0;
        VEC_TICK1: nxt_st.ctrl_second[C1_TICK1_F] = 1'b0;
        default: ;
      endcase
    end
    // events set flags last so a same-cycle clear never loses them
    c0_set[C0_EXT_F] = ext_edge; // RL11
    c0_set[C0_CMPP_F] = unit_events.timer_cmp_p;
    c0_set[C0_ADC_F] = unit_events.conv_done;
    c1_set[C1_CMPA_F] = unit_events.timer_cmp_a;
    c1_set[C1_SER_F] = unit_events.serial;
    c1_set[C1_TICK0_F] = unit_events.tick0;
    c1_set[C1_TICK1_F] = unit_events.tick1;
    nxt_st.ctrl_first = nxt_st.ctrl_first | c0_set; // RL12 RL14 RL9
    nxt_st.ctrl_second = nxt_st.ctrl_second | c1_set; // RL12 RL14
    // read channel
    if (rd_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_EDGE_SEL: nxt_st.rdata = {24'h00_0000, st_ff.edge_sel & EDGE_MASK}; // RL2
        OFS_CTRL_FIRST: nxt_st.rdata = {24'h00_0000, st_ff.ctrl_first & C0_MASK}; // RL3
        OFS_CTRL_SECOND: nxt_st.rdata = {24'h00_0000, st_ff.ctrl_second};
        OFS_VECTOR: nxt_st.rdata = {28'h000_0000, irq_req, win_vec};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  // every implemented bit resets to zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '0; // RL16
    end else begin
      st_ff <= nxt_st;
    end
  end

  // service and write steps shared by the checks below
  sequence s_service;
    irq_ack && irq_req;
  endsequence

  sequence s_ext_service;
    s_service ##0 (win_vec == VEC_EXT && !ext_edge);
  endsequence

  sequence s_cmpa_service;
    s_service ##0 (win_vec == VEC_CMPA && !unit_events.timer_cmp_a);
  endsequence

  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_gie_blocks: assert property (@(posedge clk_sys) disable iff (rst) // RL4
    !st_ff.ctrl_first[C0_GIE] |-> !irq_req)
    else $error("request while blocked");

  a_ack_clears_gie: assert property (@(posedge clk_sys) disable iff (rst) // RL13
    s_service |=> !st_ff.ctrl_first[C0_GIE])
    else $error("global enable kept after service");

  // hardware never raises the global enable, so nesting needs a software write
  a_gie_only_by_write: assert property (@(posedge clk_sys) disable iff (rst) // RL13
    !st_ff.ctrl_first[C0_GIE] && !wr_fire |=> !st_ff.ctrl_first[C0_GIE])
    else $error("global enable rose without a write");

  a_flag_records: assert property (@(posedge clk_sys) disable iff (rst) // RL12
    unit_events.conv_done |=> st_ff.ctrl_first[C0_ADC_F])
    else $error("converter flag lost");

  a_cmpp_records: assert property (@(posedge clk_sys) disable iff (rst) // RL5
    unit_events.timer_cmp_p |=> st_ff.ctrl_first[C0_CMPP_F])
    else $error("comparator p flag lost");

  a_cmpa_records: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    unit_events.timer_cmp_a |=> st_ff.ctrl_second[C1_CMPA_F])
    else $error("comparator a flag lost");

  a_serial_records: assert property (@(posedge clk_sys) disable iff (rst) // RL11
    unit_events.serial |=> st_ff.ctrl_second[C1_SER_F])
    else $error("serial flag lost");

  a_tick0_records: assert property (@(posedge clk_sys) disable iff (rst) // RL14
    unit_events.tick0 |=> st_ff.ctrl_second[C1_TICK0_F])
    else $error("tick0 flag lost");

  a_tick1_records: assert property (@(posedge clk_sys) disable iff (rst) // RL14
    unit_events.tick1 |=> st_ff.ctrl_second[C1_TICK1_F])
    else $error("tick1 flag lost");

  // own enables move only by software; events and service leave them alone
  a_enables_kept: assert property (@(posedge clk_sys) disable iff (rst) // RL9
    !wr_fire |=> $stable(st_ff.ctrl_second[3:0]) && $stable(st_ff.ctrl_first[3:1]))
    else $error("enable bit changed without a write");

  a_edge_top_zero: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    st_ff.edge_sel[7:2] == 6'h00 && st_ff.ctrl_first[7] == 1'b0)
    else $error("unimplemented bit set");

  a_rise_sets_ext: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    st_ff.edge_sel[1:0] == EDGE_RISE && !st_ff.pin_prev && ext_pin
    |=> st_ff.ctrl_first[C0_EXT_F])
    else $error("rising edge missed");

  a_fall_sets_ext: assert property (@(posedge clk_sys) disable iff (rst) // RL7
    st_ff.edge_sel[1:0] == EDGE_FALL && st_ff.pin_prev && !ext_pin
    |=> st_ff.ctrl_first[C0_EXT_F])
    else $error("falling edge missed");

  a_both_sets_ext: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    st_ff.edge_sel[1:0] == EDGE_BOTH && st_ff.pin_prev != ext_pin
    |=> st_ff.ctrl_first[C0_EXT_F])
    else $error("pin change missed");

  a_off_no_ext: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    st_ff.edge_sel[1:0] == EDGE_OFF && !st_ff.ctrl_first[C0_EXT_F] && !wr_fire
    |=> !st_ff.ctrl_first[C0_EXT_F])
    else $error("edge seen while off");

  a_ext_ack_clears: assert property (@(posedge clk_sys) disable iff (rst) // RL15
    s_ext_service |=> !st_ff.ctrl_first[C0_EXT_F])
    else $error("ext flag not cleared");

  a_cmpa_ack_clears: assert property (@(posedge clk_sys) disable iff (rst) // RL13
    s_cmpa_service |=> !st_ff.ctrl_second[C1_CMPA_F])
    else $error("comparator a flag not cleared");

  a_ext_priority: assert property (@(posedge clk_sys) disable iff (rst) // RL16
    pend[VEC_EXT] |-> irq_vector == VEC_EXT)
    else $error("priority wrong");

  // no source of higher priority may wait behind the one presented
  a_no_higher_pend: assert property (@(posedge clk_sys) disable iff (rst) // RL16
    irq_req |-> (pend & ((7'h01 << irq_vector) - 7'h01)) == 7'h00)
    else $error("higher source passed over");

  a_vector_pending: assert property (@(posedge clk_sys) disable iff (rst) // RL10
    irq_req |-> pend[irq_vector])
    else $error("vector names an idle source");

  a_read_answers: assert property (@(posedge clk_sys) disable iff (rst) // RL9
    rd_fire |=> s_axi_rvalid)
    else $error("read not answered");

  // unmapped reads answer an error with zero data
  a_read_slverr: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    rd_fire && !addr_known(s_axi_araddr)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  a_write_answers: assert property (@(posedge clk_sys) disable iff (rst) // RL17
    s_write_taken |=> s_axi_bvalid)
    else $error("write not answered");

  a_write_slverr: assert property (@(posedge clk_sys) disable iff (rst) // RL17
    s_write_taken ##0 !addr_known(s_axi_awaddr) |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
endmodule

/* File: tb/core_model.sv */
// processor core stand-in that acknowledges vectored requests
`timescale 1ns/10ps
module core_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic [2:0] irq_vector,
  input wire logic [3:0] ack_wait,
  output logic irq_ack,
  output logic [2:0] taken_vec
);
  logic [3:0] cnt_ff;
  // a real core may sit on a request for a while, so the wait is settable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_ack <= 1'b0;
      cnt_ff <= 4'h0;
      taken_vec <= 3'h7;
    end else if (irq_req && !irq_ack && cnt_ff >= ack_wait) begin
      irq_ack <= 1'b1;
      taken_vec <= irq_vector;
      cnt_ff <= 4'h0;
    end else begin
      irq_ack <= 1'b0;
      if (irq_req && !irq_ack) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule

/* File: tb/mcu_interrupt_flags_enables_tb.sv */
// self-checking bench for the interrupt flag and enable block
`timescale 1ns/10ps
module mcu_interrupt_flags_enables_tb;
  import irq_pkg::*;
  typedef struct packed {
    irq_events_t ev;
    logic [7:0] c0, c1;
    logic [2:0] vec;
    logic [7:0] c0a, c1a;
  } row_t;
  row_t rows [9] = '{'{7'h20, 8'h4E, 8'h0F, 3'h1, 8'h0E, 8'h0F},
    '{7'h10, 8'h0E, 8'h1F, 3'h2, 8'h0E, 8'h0F}, '{7'h08, 8'h2E, 8'h0F, 3'h3, 8'h0E, 8'h0F},
    '{7'h04, 8'h0E, 8'h2F, 3'h4, 8'h0E, 8'h0F}, '{7'h02, 8'h0E, 8'h4F, 3'h5, 8'h0E, 8'h0F},
    '{7'h01, 8'h0E, 8'h8F, 3'h6, 8'h0E, 8'h0F}, '{7'h28, 8'h6E, 8'h0F, 3'h1, 8'h2E, 8'h0F},
    '{7'h07, 8'h0E, 8'hEF, 3'h4, 8'h0E, 8'hCF}, '{7'h30, 8'h4E, 8'h1F, 3'h1, 8'h0E, 8'h1F}};
  logic clk_sys, rst = 1'b1, ext_pin = 1'b0, irq_req, irq_ack;
  irq_events_t ev = '0;
  logic [2:0] irq_vector, taken;
  logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
  logic [3:0] ack_wait = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0] bresp, rresp, r;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] q;
  int err_count = 0, tests_run = 0, acks = 0;
  mcu_interrupt_flags_enables mcu_interrupt_flags_enables_i (
    .clk_sys(clk_sys), .rst(rst), .ext_pin(ext_pin), .unit_events(ev),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  core_model core_model_i (.clk_sys(clk_sys), .rst(rst), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_wait(ack_wait), .irq_ack(irq_ack), .taken_vec(taken));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (irq_ack && irq_req) acks <= acks + 1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // handshakes are judged at the falling edge, so the decision never races the rising edge
  task automatic axi(input bit w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] qq, output logic [1:0] rr);
    logic ta, tw, tr;
    tr = 1'b0;
    if (w) begin
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!tr) begin
      @(negedge clk_sys);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      tr = w ? bvalid : rvalid;
      qq = rdata[7:0];
      rr = w ? bresp : rresp;
      @(posedge clk_sys);
      if (ta) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    axi(1'b1, a, d, q, r);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    axi(1'b0, a, 8'h00, q, r);
    chk(q, e);
  endtask
  task automatic wait_ack(input int k);
    int n;
    n = 0;
    while (acks < k && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    if (acks < k) err_count++;
  endtask
  task automatic summarize();
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(OFS_EDGE_SEL, 8'h00);
    rd(OFS_CTRL_FIRST, 8'h00);
    rd(OFS_CTRL_SECOND, 8'h00);
    wr(OFS_EDGE_SEL, 8'hFF);
    rd(OFS_EDGE_SEL, 8'h03);
    wr(OFS_CTRL_FIRST, 8'h80);
    rd(OFS_CTRL_FIRST, 8'h00);
    axi(1'b0, 4'h2, 8'h00, q, r);
    chk(r, RESP_SLVERR);
    chk(q, 8'h00);
    for (int i = 0; i < 9; i++) begin
      ack_wait <= i[3:0];
      wr(OFS_CTRL_FIRST, 8'h0E);
      wr(OFS_CTRL_SECOND, 8'h0F);
      ev <= rows[i].ev;
      @(posedge clk_sys);
      ev <= '0;
      rd(OFS_CTRL_FIRST, rows[i].c0);
      rd(OFS_CTRL_SECOND, rows[i].c1);
      wr(OFS_CTRL_FIRST, rows[i].c0 | 8'h01);
      wait_ack(i + 1);
      chk(taken, rows[i].vec);
      rd(OFS_CTRL_FIRST, rows[i].c0a);
      rd(OFS_CTRL_SECOND, rows[i].c1a);
    end
    ack_wait <= 4'h0;
    wr(OFS_CTRL_SECOND, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_EDGE_SEL, m[7:0]);
      wr(OFS_CTRL_FIRST, 8'h00);
      ext_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(OFS_CTRL_FIRST, {3'h0, m[0], 4'h0});
      wr(OFS_CTRL_FIRST, 8'h00);
      ext_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rd(OFS_CTRL_FIRST, {3'h0, m[1], 4'h0});
    end
    wr(OFS_EDGE_SEL, 8'h01);
    wr(OFS_CTRL_SECOND, 8'h01);
    wr(OFS_CTRL_FIRST, 8'h03);
    ext_pin <= 1'b1;
    ev <= 7'h10;
    @(posedge clk_sys);
    ev <= '0;
    wait_ack(10);
    chk(taken, VEC_EXT);
    rd(OFS_CTRL_FIRST, 8'h02);
    rd(OFS_CTRL_SECOND, 8'h11);
    rd(OFS_VECTOR, 8'h02);
    wr(4'h2, 8'hFF);
    chk(r, RESP_SLVERR);
    wstrb <= 4'h0;
    wr(OFS_CTRL_FIRST, 8'h7F);
    wstrb <= 4'hF;
    chk(r, RESP_OKAY);
    rd(OFS_CTRL_FIRST, 8'h02);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(OFS_EDGE_SEL, 8'h00);
    rd(OFS_CTRL_FIRST, 8'h00);
    rd(OFS_CTRL_SECOND, 8'h00);
    rd(OFS_VECTOR, 8'h06);
    summarize();
  end
endmodule
